//--- rtl/clock_select_defs.svh
// register map, field positions, reset values and counts of the clock block
//
// Functional notes
// RULE1 - after a second PLL config write, count slow clock edges, then flag lock
// RULE2 - multiplier 0 turns the second PLL off; 1..2047 give input times value plus one
// RULE3 - usb divider: 00 undivided, 01 by 2, 10 by 4, 11 reserved
// RULE4 - source select: 00 slow, 01 main, 10 first PLL, 11 second PLL
// RULE5 - processor prescaler divides by two to the code, 111 reserved
// RULE6 - master divider: 00 processor clock, 01 half, 10 quarter, 11 reserved
// RULE7 - each programmable clock has its own source select and prescaler
// RULE8 - writing one to an enable bit enables that interrupt, zero no effect
// RULE9 - writing one to a disable bit disables that interrupt, zero no effect
// RULE10 - mask register reads zero for enabled, one for disabled interrupt
// RULE11 - status bit 0 reads one once the main oscillator is stable
// RULE12 - status bits 1 and 2 show first and second PLL locked
// RULE13 - status bit 3 shows master clock ready
// RULE14 - status bit 7 shows slow source: 0 internal RC, 1 external crystal
// RULE15 - status bits 8 and 9 show programmable clocks 0 and 1 ready
// RULE16 - input divider: 0 gives nothing, 1 passes through, 2..255 divide
// RULE17 - interrupt output high while any enabled status flag is set
`ifndef CLOCK_SELECT_DEFS_SVH
`define CLOCK_SELECT_DEFS_SVH

`define ADDR_SECOND_PLL_CFG 32'h0ffffc2c
`define ADDR_MASTER_CLK_CFG 32'h0ffffc30
`define ADDR_PROG_CLK0_CFG 32'h0ffffc40
`define ADDR_PROG_CLK1_CFG 32'h0ffffc44
`define ADDR_IRQ_ENABLE 32'h0ffffc60
`define ADDR_IRQ_DISABLE 32'h0ffffc64
`define ADDR_STATUS 32'h0ffffc68
`define ADDR_IRQ_MASK 32'h0ffffc6c
`define ADDR_PUMP_CURRENT 32'h0ffffc80

`define PLLB_DIV_LSB 0
`define PLLB_COUNT_LSB 8
`define PLLB_RANGE_LSB 14
`define PLLB_MUL_LSB 16
`define PLLB_USB_LSB 28
`define SRC_CSS_LSB 0
`define SRC_CLOCK_PRESCALER_LSB 2
`define MCK_MASTER_DIVIDER_LSB 8
`define PUMP_A_LSB 0
`define PUMP_B_LSB 16

`define EVENT_BITS 10'h30f
`define PLLB_CFG_RESET 29'h0000_0000
`define SRC_CFG_RESET 5'h00
`define MASTER_DIVIDER_RESET 2'h0
`define PUMP_RESET 1'h0
`define READY_WAIT_EDGES 2'h2

`endif

//--- rtl/clock_select_pkg.sv
// types shared by the clock select and status block
package clock_select_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] usb_clock_divider;
    logic [10:0] mul;
    logic [1:0] range;
    logic [5:0] count;
    logic [7:0] div;
  } pllb_cfg_t;

  typedef struct packed {
    logic [2:0] clock_prescaler;
    logic [1:0] clock_source_select;
  } src_cfg_t;

  typedef enum logic [2:0] {
    LOCK_OFF = 3'b001,
    LOCK_COUNT = 3'b010,
    LOCK_DONE = 3'b100
  } lock_state_t;

  typedef struct packed {
    logic processorClk;
    logic masterClk;
    logic usbClk;
    logic [1:0] progClk;
    logic refOut;
  } clk_out_t;

  typedef struct packed {
    pllb_cfg_t pllb;
    lock_state_t lockState;
    logic [5:0] lockCnt;
    src_cfg_t mck;
    logic [1:0] master_divider;
    src_cfg_t [1:0] pck;
    logic [9:0] irqEnable;
    logic pumpA;
    logic pumpB;
    logic [3:0] srcPrev;
    logic [5:0] mckCnt;
    logic procPrev;
    logic [1:0] mdivCnt;
    logic [1:0] usbCnt;
    logic [1:0][5:0] pckCnt;
    logic refPrev;
    logic [7:0] divCnt;
    logic mckReady;
    logic [1:0] mckWait;
    logic [1:0] pckReady;
    logic [1:0][1:0] pckWait;
    logic main_osc_stable;
    logic firstLock;
    logic slowSel;
    clk_out_t clk;
    logic irq;
    logic [31:0] readData;
  } state_t;

endpackage : clock_select_pkg

//--- rtl/clock_select_status.sv
// master clock select, prescalers, second PLL control and clock status
`timescale 1ns/1ns
`default_nettype none
`include "clock_select_defs.svh"

module clock_select_status (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire clock_select_pkg::reg_req_t req,
  output logic [31:0] readData,
  // sampled clock sources
  input wire logic slowClk,
  input wire logic mainClk,
  input wire logic firstPllClk,
  input wire logic secondPllClk,
  input wire logic pllRefClk,
  // analog status inputs
  input wire logic mainOscStable,
  input wire logic firstPllLocked,
  input wire logic slowSourceSelect,
  // generated clocks
  output logic processorClk,
  output logic masterClk,
  output logic usbClk,
  output logic [1:0] progClk,
  output logic pllRefDivOut,
  // second PLL and pump controls
  output logic secondPllPowerOn,
  output logic [10:0] secondPllMultiplier,
  output logic [1:0] secondPllFreqRange,
  output logic firstPllPumpCurrent,
  output logic secondPllPumpCurrent,
  // interrupt
  output logic clockIrq
);
  import clock_select_pkg::*;

  state_t s;
  state_t n;

  logic [3:0] srcNow;
  logic [3:0] srcEdge;
  logic [9:0] statusNow;
  logic mckSel;
  logic mckEdge;
  logic procEdge;
  logic usbEdge;
  logic refEdge;
  logic pllbWrite;
  logic mckWrite;
  logic [1:0] pckWrite;

  // divide by two to the code; reserved code holds the output low
  function automatic logic presSel(input logic src, input logic [5:0] cnt,
                                   input logic [2:0] code);
    logic r;
    r = 1'b0;
    if (code == 3'h0) begin
      r = src;
    end else if (code != 3'h7) begin
      r = cnt[code - 3'h1];
    end
    return r;
  endfunction : presSel

  // power-of-two divider on a 2-bit counter; code 11 holds low
  function automatic logic div4Sel(input logic src, input logic [1:0] cnt,
                                   input logic [1:0] code);
    logic r;
    r = 1'b0;
    case (code)
      2'h0: r = src;
      2'h1: r = cnt[0];
      2'h2: r = cnt[1];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : div4Sel

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = s;
    srcNow = {secondPllClk, firstPllClk, mainClk, slowClk}; // RULE4
    srcEdge = srcNow & ~s.srcPrev;
    statusNow = {s.pckReady, s.slowSel, 3'h0, s.mckReady,
                 (s.lockState == LOCK_DONE), s.firstLock, s.main_osc_stable};
    mckSel = srcNow[s.mck.clock_source_select]; // RULE4
    mckEdge = srcEdge[s.mck.clock_source_select];
    procEdge = s.clk.processorClk & ~s.procPrev;
    usbEdge = srcEdge[3];
    refEdge = pllRefClk & ~s.refPrev;
    pllbWrite = req.wr && (req.addr == `ADDR_SECOND_PLL_CFG);
    mckWrite = req.wr && (req.addr == `ADDR_MASTER_CLK_CFG);
    pckWrite[0] = req.wr && (req.addr == `ADDR_PROG_CLK0_CFG);
    pckWrite[1] = req.wr && (req.addr == `ADDR_PROG_CLK1_CFG);

    n.srcPrev = srcNow;
    n.procPrev = s.clk.processorClk;
    n.refPrev = pllRefClk;
    n.main_osc_stable = mainOscStable; // RULE11
    n.firstLock = firstPllLocked; // RULE12
    n.slowSel = slowSourceSelect; // RULE14

    // second PLL lock counter on slow clock edges
    case (s.lockState)
      LOCK_OFF: begin
        n.lockState = LOCK_OFF;
      end
      LOCK_COUNT: begin
        if (srcEdge[0]) begin
          if (s.lockCnt == 6'h0) begin
            n.lockState = LOCK_DONE; // RULE1
          end else begin
            n.lockCnt = s.lockCnt - 6'h1; // RULE1
          end
        end
      end
      LOCK_DONE: begin
        n.lockState = LOCK_DONE;
      end
      default: begin
        n.lockState = LOCK_OFF;
      end
    endcase

    // register writes
    if (pllbWrite) begin
      n.pllb.div = req.wdata[`PLLB_DIV_LSB +: 8];
      n.pllb.count = req.wdata[`PLLB_COUNT_LSB +: 6];
      n.pllb.range = req.wdata[`PLLB_RANGE_LSB +: 2];
      n.pllb.mul = req.wdata[`PLLB_MUL_LSB +: 11];
      n.pllb.usb_clock_divider = req.wdata[`PLLB_USB_LSB +: 2];
      n.lockCnt = req.wdata[`PLLB_COUNT_LSB +: 6]; // RULE1
      n.lockState = (req.wdata[`PLLB_MUL_LSB +: 11] == 11'h0) ?
                    LOCK_OFF : LOCK_COUNT; // RULE2
      n.divCnt = 8'h0;
    end
    if (mckWrite) begin
      n.mck.clock_source_select = req.wdata[`SRC_CSS_LSB +: 2];
      n.mck.clock_prescaler = req.wdata[`SRC_CLOCK_PRESCALER_LSB +: 3];
      n.master_divider = req.wdata[`MCK_MASTER_DIVIDER_LSB +: 2];
    end
    if (req.wr && (req.addr == `ADDR_PUMP_CURRENT)) begin
      n.pumpA = req.wdata[`PUMP_A_LSB];
      n.pumpB = req.wdata[`PUMP_B_LSB];
    end
    if (req.wr && (req.addr == `ADDR_IRQ_ENABLE)) begin
      n.irqEnable = s.irqEnable | (req.wdata[9:0] & `EVENT_BITS); // RULE8
    end
    if (req.wr && (req.addr == `ADDR_IRQ_DISABLE)) begin
      n.irqEnable = s.irqEnable & ~(req.wdata[9:0] & `EVENT_BITS); // RULE9
    end

    // processor prescaler and master divider
    if (mckEdge) begin
      n.mckCnt = s.mckCnt + 6'h1;
    end
    n.clk.processorClk = presSel(mckSel, s.mckCnt, s.mck.clock_prescaler); // RULE5
    if (procEdge) begin
      n.mdivCnt = s.mdivCnt + 2'h1;
    end
    n.clk.masterClk = div4Sel(s.clk.processorClk, s.mdivCnt, s.master_divider); // RULE6

    // master ready drops on a reconfiguration, returns after source edges
    if (mckWrite) begin
      n.mckReady = 1'b0; // RULE13
      n.mckWait = `READY_WAIT_EDGES;
    end else if (!s.mckReady && mckEdge) begin
      if (s.mckWait == 2'h1) begin
        n.mckReady = 1'b1; // RULE13
      end
      n.mckWait = s.mckWait - 2'h1;
    end

    // programmable clocks
    for (int i = 0; i < 2; i++) begin
      if (srcEdge[s.pck[i].clock_source_select]) begin
        n.pckCnt[i] = s.pckCnt[i] + 6'h1;
      end
      n.clk.progClk[i] = presSel(srcNow[s.pck[i].clock_source_select], s.pckCnt[i],
                                 s.pck[i].clock_prescaler); // RULE7
      if (pckWrite[i]) begin
        n.pck[i].clock_source_select = req.wdata[`SRC_CSS_LSB +: 2];
        n.pck[i].clock_prescaler = req.wdata[`SRC_CLOCK_PRESCALER_LSB +: 3];
        n.pckReady[i] = 1'b0; // RULE15
        n.pckWait[i] = `READY_WAIT_EDGES;
      end else if (!s.pckReady[i] && srcEdge[s.pck[i].clock_source_select]) begin
        if (s.pckWait[i] == 2'h1) begin
          n.pckReady[i] = 1'b1; // RULE15
        end
        n.pckWait[i] = s.pckWait[i] - 2'h1;
      end
    end

    // usb divider on second PLL output
    if (usbEdge) begin
      n.usbCnt = s.usbCnt + 2'h1;
    end
    n.clk.usbClk = div4Sel(secondPllClk, s.usbCnt, s.pllb.usb_clock_divider); // RULE3

    // second PLL input divider
    if (refEdge && !pllbWrite) begin
      n.divCnt = (s.divCnt >= s.pllb.div - 8'h1) ? 8'h0 : s.divCnt + 8'h1;
    end
    if (s.pllb.div == 8'h0) begin
      n.clk.refOut = 1'b0; // RULE16
    end else if (s.pllb.div == 8'h1) begin
      n.clk.refOut = pllRefClk; // RULE16
    end else begin
      n.clk.refOut = (s.divCnt < {1'b0, s.pllb.div[7:1]}); // RULE16
    end

    n.irq = |(statusNow & s.irqEnable); // RULE17

    // register reads, data in the following cycle
    n.readData = 32'h0;
    if (req.rd) begin
      case (req.addr)
        `ADDR_SECOND_PLL_CFG: n.readData = {3'h0, s.pllb};
        `ADDR_MASTER_CLK_CFG: n.readData = {22'h0, s.master_divider, 3'h0, s.mck};
        `ADDR_PROG_CLK0_CFG: n.readData = {27'h0, s.pck[0]};
        `ADDR_PROG_CLK1_CFG: n.readData = {27'h0, s.pck[1]};
        `ADDR_STATUS: n.readData = {22'h0, statusNow}; // RULE12
        `ADDR_IRQ_MASK: n.readData = {22'h0, ~s.irqEnable & `EVENT_BITS}; // RULE10
        `ADDR_PUMP_CURRENT: n.readData = {15'h0, s.pumpB, 15'h0, s.pumpA};
        default: n.readData = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.pllb <= `PLLB_CFG_RESET;
      s.lockState <= LOCK_OFF;
      s.mck <= `SRC_CFG_RESET;
      s.master_divider <= `MASTER_DIVIDER_RESET;
      s.pck <= {`SRC_CFG_RESET, `SRC_CFG_RESET};
      s.pumpA <= `PUMP_RESET;
      s.pumpB <= `PUMP_RESET;
      s.mckWait <= `READY_WAIT_EDGES;
      s.pckWait <= {`READY_WAIT_EDGES, `READY_WAIT_EDGES};
    end else begin
      s <= n;
    end
  end

  assign readData = s.readData;
  assign processorClk = s.clk.processorClk;
  assign masterClk = s.clk.masterClk;
  assign usbClk = s.clk.usbClk;
  assign progClk = s.clk.progClk;
  assign pllRefDivOut = s.clk.refOut;
  assign secondPllPowerOn = (s.lockState != LOCK_OFF); // RULE2
  assign secondPllMultiplier = s.pllb.mul;
  assign secondPllFreqRange = s.pllb.range;
  assign firstPllPumpCurrent = s.pumpA;
  assign secondPllPumpCurrent = s.pumpB;
  assign clockIrq = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_pllb_write;
    pllbWrite && (req.wdata[`PLLB_MUL_LSB +: 11] != 11'h0);
  endsequence

  sequence s_lock_off_write;
    pllbWrite && (req.wdata[`PLLB_MUL_LSB +: 11] == 11'h0);
  endsequence

  property p_lock_after_write;
    @(posedge core_clk) disable iff (!reset_n)
    s_pllb_write |=> (s.lockState == LOCK_COUNT) && !statusNow[2];
  endproperty
  a_lock_after_write: assert property (p_lock_after_write) // RULE1
    else $error("second PLL lock set too early");

  property p_mul_zero_off;
    @(posedge core_clk) disable iff (!reset_n)
    s_lock_off_write |=> !secondPllPowerOn && !statusNow[2];
  endproperty
  a_mul_zero_off: assert property (p_mul_zero_off) // RULE2
    else $error("second PLL not off for multiplier zero");

  property p_usb_undivided;
    @(posedge core_clk) disable iff (!reset_n)
    (s.pllb.usb_clock_divider == 2'h0) && !pllbWrite |=> usbClk == $past(secondPllClk);
  endproperty
  a_usb_undivided: assert property (p_usb_undivided) // RULE3
    else $error("usb clock not following second PLL");

  property p_proc_undivided;
    @(posedge core_clk) disable iff (!reset_n)
    (s.mck.clock_prescaler == 3'h0) && !mckWrite |=> processorClk == $past(mckSel);
  endproperty
  a_proc_undivided: assert property (p_proc_undivided) // RULE5
    else $error("processor clock not following source");

  property p_irq_enable;
    @(posedge core_clk) disable iff (!reset_n)
    req.wr && (req.addr == `ADDR_IRQ_ENABLE) && req.wdata[0] |=>
      s.irqEnable[0];
  endproperty
  a_irq_enable: assert property (p_irq_enable) // RULE8
    else $error("enable write did not enable");

  property p_irq_disable;
    @(posedge core_clk) disable iff (!reset_n)
    req.wr && (req.addr == `ADDR_IRQ_DISABLE) && req.wdata[3] |=>
      !s.irqEnable[3];
  endproperty
  a_irq_disable: assert property (p_irq_disable) // RULE9
    else $error("disable write did not disable");

  property p_mask_read;
    @(posedge core_clk) disable iff (!reset_n)
    req.rd && (req.addr == `ADDR_IRQ_MASK) |=>
      readData[9:0] == (~$past(s.irqEnable) & `EVENT_BITS);
  endproperty
  a_mask_read: assert property (p_mask_read) // RULE10
    else $error("mask read not inverse of enables");

  property p_slow_sel_read;
    @(posedge core_clk) disable iff (!reset_n)
    req.rd && (req.addr == `ADDR_STATUS) |=> readData[7] == $past(s.slowSel);
  endproperty
  a_slow_sel_read: assert property (p_slow_sel_read) // RULE14
    else $error("slow source bit wrong");

  property p_mck_ready_drop;
    @(posedge core_clk) disable iff (!reset_n)
    mckWrite |=> !statusNow[3] ##1 !statusNow[3];
  endproperty
  a_mck_ready_drop: assert property (p_mck_ready_drop) // RULE13
    else $error("master ready not dropped on reconfiguration");

  property p_irq_level;
    @(posedge core_clk) disable iff (!reset_n)
    |(statusNow & s.irqEnable) |=> clockIrq;
  endproperty
  a_irq_level: assert property (p_irq_level) // RULE17
    else $error("interrupt not raised for enabled flag");

endmodule : clock_select_status
`default_nettype wire

//--- tb/clock_select_status_tb.sv
// self-checking bench for the clock select and status block
`timescale 1ns/1ns
`default_nettype none
`include "clock_select_defs.svh"

module clock_select_status_tb;
  import clock_select_pkg::*;

  logic core_clk;
  logic reset_n;
  reg_req_t req;
  logic [31:0] readData;
  logic [3:0] tick;
  logic mainOscStable;
  logic firstPllLocked;
  logic slowSourceSelect;
  logic processorClk;
  logic masterClk;
  logic usbClk;
  logic [1:0] progClk;
  logic pllRefDivOut;
  logic secondPllPowerOn;
  logic [10:0] secondPllMultiplier;
  logic [1:0] secondPllFreqRange;
  logic firstPllPumpCurrent;
  logic secondPllPumpCurrent;
  logic clockIrq;
  logic [5:0] obs;
  int srcPeriod [4] = '{16, 2, 4, 8};
  int n_errors = 0;
  int check_count = 0;

  // sources: main and ref /2, first pll /4, second pll /8, slow /16
  clock_select_status clock_select_status_i (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .req(req),
    .readData(readData),
    .slowClk(tick[3]),
    .mainClk(tick[0]),
    .firstPllClk(tick[1]),
    .secondPllClk(tick[2]),
    .pllRefClk(tick[0]),
    .mainOscStable(mainOscStable),
    .firstPllLocked(firstPllLocked),
    .slowSourceSelect(slowSourceSelect),
    .processorClk(processorClk),
    .masterClk(masterClk),
    .usbClk(usbClk),
    .progClk(progClk),
    .pllRefDivOut(pllRefDivOut),
    .secondPllPowerOn(secondPllPowerOn),
    .secondPllMultiplier(secondPllMultiplier),
    .secondPllFreqRange(secondPllFreqRange),
    .firstPllPumpCurrent(firstPllPumpCurrent),
    .secondPllPumpCurrent(secondPllPumpCurrent),
    .clockIrq(clockIrq)
  );

  assign obs = {pllRefDivOut, progClk, usbClk, masterClk, processorClk};

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial tick = 4'h0;
  always @(posedge core_clk) tick <= tick + 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task check(input logic [31:0] got, input logic [31:0] exp,
             input string msg);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  task wr(input logic [31:0] a, input logic [31:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
          input string msg);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    check(readData & m, e, msg);
    @(posedge core_clk);
    #1;
    check(readData, 32'h0, "read data held too long");
    @(posedge core_clk);
  endtask : rd

  // cycles until the next rising edge of one observed clock
  task rise(input int idx, output int n);
    logic prev;
    n = 0;
    prev = obs[idx];
    while (n < 1000) begin
      @(posedge core_clk);
      #1;
      n++;
      if (obs[idx] && !prev) break;
      prev = obs[idx];
    end
  endtask : rise

  // first two edges after a change are discarded
  task period(input int idx, input int exp);
    int n;
    rise(idx, n);
    rise(idx, n);
    rise(idx, n);
    check(n, exp, "clock period");
  endtask : period

  task held_low(input int idx);
    int highs;
    highs = 0;
    repeat (300) begin
      @(posedge core_clk);
      #1;
      if (obs[idx] !== 1'b0) highs++;
    end
    check(highs, 0, "reserved code clock not low");
  endtask : held_low

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(`ADDR_IRQ_MASK, 32'hffffffff, 32'h30f, "mask after reset");
    rd(`ADDR_STATUS, 32'h7, 32'h0, "status after reset");
    check(clockIrq, 1'b0, "irq after reset");
    wr(32'h0ffffc50, 32'hffffffff);
    rd(32'h0ffffc50, 32'hffffffff, 32'h0, "unmapped read");
    wr(`ADDR_PUMP_CURRENT, 32'h00010001);
    rd(`ADDR_PUMP_CURRENT, 32'hffffffff, 32'h00010001, "pump readback");
    check({firstPllPumpCurrent, secondPllPumpCurrent}, 2'b11, "pump out");
    wr(`ADDR_MASTER_CLK_CFG, 32'h109);
    rd(`ADDR_MASTER_CLK_CFG, 32'h31f, 32'h109, "master readback");
    wr(`ADDR_IRQ_MASK, 32'h0);
    rd(`ADDR_IRQ_MASK, 32'hffffffff, 32'h30f, "mask is read only");
  endtask : t_reset

  task t_irq;
    wr(`ADDR_IRQ_ENABLE, 32'h30f);
    rd(`ADDR_IRQ_MASK, 32'hffffffff, 32'h0, "all enabled");
    wr(`ADDR_IRQ_DISABLE, 32'h30e);
    rd(`ADDR_IRQ_MASK, 32'hffffffff, 32'h30e, "one enabled");
    wr(`ADDR_IRQ_ENABLE, 32'h0);
    rd(`ADDR_IRQ_MASK, 32'hffffffff, 32'h30e, "enable zero");
    check(clockIrq, 1'b0, "irq idle");
    mainOscStable <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check(clockIrq, 1'b1, "irq raised");
    wr(`ADDR_IRQ_DISABLE, 32'h0);
    rd(`ADDR_IRQ_MASK, 32'hffffffff, 32'h30e, "disable zero");
    wr(`ADDR_IRQ_DISABLE, 32'h1);
    rd(`ADDR_IRQ_MASK, 32'hffffffff, 32'h30f, "disabled");
    check(clockIrq, 1'b0, "irq masked");
    mainOscStable <= 1'b0;
  endtask : t_irq

  task t_status;
    firstPllLocked <= 1'b1;
    slowSourceSelect <= 1'b1;
    mainOscStable <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(`ADDR_STATUS, 32'h83, 32'h83, "inputs set");
    firstPllLocked <= 1'b0;
    slowSourceSelect <= 1'b0;
    mainOscStable <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(`ADDR_STATUS, 32'h83, 32'h0, "inputs clear");
  endtask : t_status

  task t_ready;
    wr(`ADDR_MASTER_CLK_CFG, 32'h0);
    wr(`ADDR_PROG_CLK0_CFG, 32'h0);
    wr(`ADDR_PROG_CLK1_CFG, 32'h0);
    rd(`ADDR_STATUS, 32'h308, 32'h0, "not ready");
    repeat (40) @(posedge core_clk);
    rd(`ADDR_STATUS, 32'h308, 32'h308, "ready");
  endtask : t_ready

  task t_lock;
    @(posedge tick[3]);
    repeat (2) @(posedge core_clk);
    wr(`ADDR_SECOND_PLL_CFG, 32'h0001_4300);
    #1;
    check(secondPllPowerOn, 1'b1, "pll on");
    check(secondPllFreqRange, 2'h1, "freq range");
    check(secondPllMultiplier, 11'h001, "multiplier");
    repeat (3) @(posedge tick[3]);
    repeat (3) @(posedge core_clk);
    rd(`ADDR_STATUS, 32'h4, 32'h0, "lock early");
    @(posedge tick[3]);
    repeat (3) @(posedge core_clk);
    rd(`ADDR_STATUS, 32'h4, 32'h4, "lock set");
    wr(`ADDR_IRQ_ENABLE, 32'h4);
    #1;
    check(clockIrq, 1'b1, "lock irq");
    wr(`ADDR_IRQ_DISABLE, 32'h4);
    wr(`ADDR_SECOND_PLL_CFG, 32'h0);
    #1;
    check(secondPllPowerOn, 1'b0, "pll off");
    rd(`ADDR_STATUS, 32'h4, 32'h0, "lock cleared");
  endtask : t_lock

  task t_master;
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_MASTER_CLK_CFG, c);
      period(0, srcPeriod[c]);
      period(1, srcPeriod[c]);
    end
    for (int p = 0; p < 7; p++) begin
      wr(`ADDR_MASTER_CLK_CFG, (p << 2) | 1);
      period(0, 2 << p);
    end
    wr(`ADDR_MASTER_CLK_CFG, 32'h105);
    period(1, 8);
    wr(`ADDR_MASTER_CLK_CFG, 32'h205);
    period(1, 16);
    wr(`ADDR_MASTER_CLK_CFG, 32'h1d);
    held_low(0);
  endtask : t_master

  task t_prog;
    for (int i = 0; i < 2; i++) begin
      for (int c = 0; c < 4; c++) begin
        wr(`ADDR_PROG_CLK0_CFG + 4 * i, (i << 2) | c);
        period(3 + i, srcPeriod[c] << i);
      end
    end
    wr(`ADDR_PROG_CLK0_CFG, 32'h16);
    period(3, 4 << 5);
    wr(`ADDR_PROG_CLK1_CFG, 32'h1d);
    held_low(4);
  endtask : t_prog

  task t_usb;
    for (int u = 0; u < 3; u++) begin
      wr(`ADDR_SECOND_PLL_CFG, (u << 28) | 32'h0001_0001);
      period(2, 8 << u);
      period(5, 2);
    end
    wr(`ADDR_SECOND_PLL_CFG, 32'h3001_0003);
    held_low(2);
    period(5, 6);
    wr(`ADDR_SECOND_PLL_CFG, 32'h0001_0000);
    held_low(5);
  endtask : t_usb

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(30000 * 100);
    n_errors++;
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    req = '0;
    mainOscStable = 1'b0;
    firstPllLocked = 1'b0;
    slowSourceSelect = 1'b0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_irq();
    t_status();
    t_ready();
    t_lock();
    t_master();
    t_prog();
    t_usb();
    complete_run();
  end

endmodule : clock_select_status_tb
`default_nettype wire
